/* File: design/sdi_func_logic.sv */
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
// Purpose: Decodes digital input terminal functions into servo control actions.
// Assumes: Parameters written over APB; terminal inputs are asynchronous levels.
// Notes: The command path is registered, so outputs follow inputs by three cycles.
module sdi_func_logic
  import sdi_pkg::*;
#(
  parameter int unsigned W = CMD_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic zero_speed_clamp_input,
  input wire logic command_zero_input,
  input wire logic command_reverse_input,
  input wire logic speed_select_low,
  input wire logic speed_select_high,
  input wire logic torque_select_low,
  input wire logic torque_select_high,
  input wire logic mode_switch_input,
  input wire logic gear_select_low,
  input wire logic gear_select_high,
  input wire logic deviation_clear_input,
  input wire logic pulse_inhibit_input,
  input wire logic ccw_jog_input,
  input wire logic cw_jog_input,
  input wire logic move_pause_input,
  input wire logic move_trigger_input,
  input wire logic [2:0] position_select_inputs,
  input wire logic zero_speed_indicator,
  output logic [1:0] active_ctrl_mode,
  output logic [W-1:0] speed_command,
  output logic [W-1:0] torque_command,
  output logic [W-1:0] gear_numerator,
  output logic deviation_clear,
  output logic pulse_accept,
  output logic move_hold,
  output logic move_start,
  output logic [2:0] move_register
);
  // Settings held for the decode, one field per drive parameter.
  logic [3:0] control_mode_setting;
  logic [3:0] speed_source_setting;
  logic [3:0] torque_source_setting;
  logic [3:0] internal_position_mode_setting;
  logic [3:0] gear_select_setting;
  logic [W-1:0] zero_speed_threshold;
  logic [W-1:0] jog_speed_setting;
  logic [W-1:0] ext_speed_q;
  logic [W-1:0] ext_torque_q;
  logic [W-1:0] preset_speed [4];
  logic [W-1:0] preset_torque [4];
  logic [W-1:0] gear_num [4];
  logic [N_INPUTS-1:0] pins;
  logic [N_INPUTS-1:0] s;
  logic trig_prev_q;
  sdi_move_t move_q;
  sdi_ctrl_t mode_d;
  logic [W-1:0] speed_d;
  logic [W-1:0] torque_d;
  logic [W-1:0] abs_speed;
  logic clamp_active;
  logic jog_ccw;
  logic jog_cw;
  logic trig_rise;
  logic wr_en;
  logic rd_en;
  logic addr_mapped;

  sdi_sync_if #(.WIDTH(N_INPUTS)) sif ();

  // Terminal packing; the decode below relies on these bit positions.
  assign pins = {zero_speed_indicator, position_select_inputs, move_trigger_input, move_pause_input,
                 cw_jog_input, ccw_jog_input, pulse_inhibit_input, deviation_clear_input,
                 gear_select_high, gear_select_low, mode_switch_input, torque_select_high,
                 torque_select_low, speed_select_high, speed_select_low, command_reverse_input,
                 command_zero_input, zero_speed_clamp_input};
  assign sif.raw = pins;
  assign s = sif.sync;

  // All terminal levels cross into the clock domain before any decoding.
  sdi_input_sync #(.WIDTH(N_INPUTS)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .sif(sif)
  );

  // Zero wait states: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // Register writes; unmapped offsets are ignored and flagged through pslverr.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_mode_setting <= MODE_RESET;
      speed_source_setting <= SSRC_EXTERNAL;
      torque_source_setting <= 4'h0;
      internal_position_mode_setting <= 4'h0;
      gear_select_setting <= 4'h0;
      zero_speed_threshold <= '0;
      jog_speed_setting <= '0;
      ext_speed_q <= '0;
      ext_torque_q <= '0;
      for (int k = 0; k < 4; k++) begin
        preset_speed[k] <= '0;
        preset_torque[k] <= '0;
        gear_num[k] <= '0;
      end
    end else if (wr_en) begin
      if (paddr == REG_MODE) begin
        control_mode_setting <= pwdata[3:0];
        internal_position_mode_setting <= pwdata[7:4];
        gear_select_setting <= pwdata[11:8];
      end else if (paddr == REG_SRC) begin
        speed_source_setting <= pwdata[3:0];
        torque_source_setting <= pwdata[7:4];
      end else if (paddr == REG_THRESH) begin
        zero_speed_threshold <= pwdata[W-1:0];
      end else if (paddr == REG_JOG) begin
        jog_speed_setting <= pwdata[W-1:0];
      end else if (paddr == REG_EXT_CMD) begin
        // Low half is the speed word, high half the torque word.
        ext_speed_q <= pwdata[W-1:0];
        ext_torque_q <= pwdata[31:16];
      end else begin
        // Four words per bank share one decode loop.
        for (int k = 0; k < 4; k++) begin
          if (paddr == REG_SPEED0 + 12'(4 * k)) begin
            preset_speed[k] <= pwdata[W-1:0];
          end else if (paddr == REG_TORQUE0 + 12'(4 * k)) begin
            preset_torque[k] <= pwdata[W-1:0];
          end else if (paddr == REG_GEAR0 + 12'(4 * k)) begin
            gear_num[k] <= pwdata[W-1:0];
          end
        end
      end
    end
  end

  // Read data is registered in the setup cycle so it is stable in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      // Unmapped offsets read back as zero.
      prdata <= 32'h0000_0000;
      if (paddr == REG_MODE) begin
        prdata <= {20'h00000, gear_select_setting, internal_position_mode_setting, control_mode_setting};
      end else if (paddr == REG_SRC) begin
        prdata <= {24'h000000, torque_source_setting, speed_source_setting};
      end else if (paddr == REG_THRESH) begin
        prdata <= {16'h0000, zero_speed_threshold};
      end else if (paddr == REG_JOG) begin
        prdata <= {16'h0000, jog_speed_setting};
      end else if (paddr == REG_EXT_CMD) begin
        prdata <= {ext_torque_q, ext_speed_q};
      end else if (paddr == REG_STATUS) begin
        prdata <= {22'h000000, move_register, move_start, move_hold, pulse_accept,
                   deviation_clear, (move_q == SDI_MOVING), active_ctrl_mode};
      end else if (paddr == REG_OUT_CMD) begin
        prdata <= {torque_command, speed_command};
      end else if (paddr == REG_GEAR_OUT) begin
        prdata <= {16'h0000, gear_numerator};
      end else begin
        for (int k = 0; k < 4; k++) begin
          if (paddr == REG_SPEED0 + 12'(4 * k)) begin
            prdata <= {16'h0000, preset_speed[k]};
          end else if (paddr == REG_TORQUE0 + 12'(4 * k)) begin
            prdata <= {16'h0000, preset_torque[k]};
          end else if (paddr == REG_GEAR0 + 12'(4 * k)) begin
            prdata <= {16'h0000, gear_num[k]};
          end
        end
      end
    end
  end

  // Aligned words up to the command word and from the first preset through the gear output word are mapped.
  assign addr_mapped = (paddr[1:0] == 2'b00)
                       && ((paddr <= REG_EXT_CMD) || (paddr >= REG_SPEED0 && paddr <= REG_GEAR_OUT));

  // Error response for offsets that hold no register.
  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      pslverr = !addr_mapped;
    end
  end

  // Active control mode; unknown settings fall back to position control.
  always_comb begin
    mode_d = SDI_POSITION;
    case (control_mode_setting)
      MODE_SPEED: mode_d = SDI_SPEED;
      MODE_TORQUE: mode_d = SDI_TORQUE;
      MODE_POS_SPEED: mode_d = s[7] ? SDI_SPEED : SDI_POSITION; // R6
      MODE_POS_TORQUE: mode_d = s[7] ? SDI_TORQUE : SDI_POSITION; // R7
      MODE_SPEED_TORQUE: mode_d = s[7] ? SDI_TORQUE : SDI_SPEED; // R8
      default: mode_d = SDI_POSITION;
    endcase
  end

  // Magnitude of the external command; the clamp compares without direction.
  assign abs_speed = ext_speed_q[W-1] ? W'(-ext_speed_q) : ext_speed_q;
  assign clamp_active = (control_mode_setting == MODE_SPEED) && (speed_source_setting == SSRC_EXTERNAL)
                        && s[0] && (abs_speed < zero_speed_threshold); // R1 R2
  assign jog_ccw = s[12] && !s[13]; // R12 R14
  assign jog_cw = s[13] && !s[12]; // R13 R14

  // Command selection, then zero and reverse modifiers on the chosen command.
  always_comb begin
    speed_d = ext_speed_q; // R2
    torque_d = ext_torque_q;
    if (mode_d == SDI_SPEED) begin
      if (speed_source_setting == SSRC_INTERNAL) begin
        speed_d = preset_speed[{s[4], s[3]}]; // R4
      end else if (speed_source_setting == SSRC_JOG) begin
        speed_d = '0; // R14
        if (jog_ccw) begin
          speed_d = jog_speed_setting; // R12
        end else if (jog_cw) begin
          speed_d = W'(-jog_speed_setting); // R13
        end
      end else if (clamp_active) begin
        speed_d = '0; // R1
      end
    end
    if (mode_d == SDI_TORQUE && torque_source_setting == TSRC_INTERNAL) begin
      torque_d = preset_torque[{s[6], s[5]}]; // R5
    end
    // Zero wins over reverse since a reversed zero is still zero.
    if (mode_d != SDI_POSITION) begin
      if (s[1]) begin
        speed_d = '0; // R3
        torque_d = '0;
      end else if (s[2]) begin
        speed_d = W'(-speed_d); // R3
        torque_d = W'(-torque_d);
      end
    end
    // The torque command leaves only in torque mode; the speed command is zeroed only in position mode.
    if (mode_d != SDI_SPEED) begin
      speed_d = (mode_d == SDI_POSITION) ? '0 : speed_d;
    end
    if (mode_d != SDI_TORQUE) begin
      torque_d = '0;
    end
  end

  // Registered command outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_ctrl_mode <= 2'h0;
      speed_command <= '0;
      torque_command <= '0;
    end else begin
      active_ctrl_mode <= mode_d;
      speed_command <= speed_d;
      torque_command <= torque_d;
    end
  end

  // Gear numerator; with other selections the first numerator stays in use.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gear_numerator <= '0;
    end else if (gear_select_setting == 4'h0) begin
      gear_numerator <= gear_num[{s[9], s[8]}]; // R9
    end else begin
      gear_numerator <= gear_num[0];
    end
  end

  // Position mode pulse gating and deviation clear as levels.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deviation_clear <= 1'b0;
      pulse_accept <= 1'b0;
    end else begin
      deviation_clear <= (mode_d == SDI_POSITION) && s[10]; // R10
      pulse_accept <= (mode_d == SDI_POSITION) && !s[11]; // R11
    end
  end

  // Pause only acts when the internal position mode allows it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      move_hold <= 1'b0;
    end else begin
      move_hold <= (internal_position_mode_setting == IPOS_MODE_PAUSE) && s[14]; // R15
    end
  end

  // Rising edge of the synchronised trigger; a held trigger starts one move only.
  // The previous level resets low like the idle pin, so reset gives no false edge.
  assign trig_rise = s[15] && !trig_prev_q; // R18

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= s[15];
    end
  end

  // Move start latches the selected register; busy until the motor reports zero speed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      move_q <= SDI_IDLE;
      move_start <= 1'b0;
      move_register <= 3'h0;
    end else begin
      move_start <= 1'b0;
      case (move_q)
        SDI_IDLE: begin
          if (trig_rise && s[19]) begin // R17
            move_start <= 1'b1; // R16
            move_register <= s[18:16]; // R16
            move_q <= SDI_MOVING;
          end
        end
        SDI_MOVING: begin
          if (trig_rise && s[19]) begin // R17
            move_start <= 1'b1;
            move_register <= s[18:16];
          end else if (s[19] && !move_start) begin
            move_q <= SDI_IDLE;
          end
        end
        default: move_q <= SDI_IDLE;
      endcase
    end
  end
endmodule

/* File: design/sdi_input_sync.sv */
`timescale 1ns/100ps
// Purpose: Two-flop synchroniser for every terminal input.
// Assumes: Inputs are slow levels from pins.
// Notes: The first stage feeds only the second stage.
module sdi_input_sync
  import sdi_pkg::*;
#(
  parameter int unsigned WIDTH = 19
) (
  input wire logic pclk,
  input wire logic presetn,
  sdi_sync_if.syn sif
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // Each bit passes two flops before any logic reads it.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= sif.raw[i]; // R18
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign sif.sync = sync_q;
endmodule

/* File: design/sdi_pkg.sv */
// Purpose: Constants and types for the servo digital input function logic.
// Assumes: Signed 16-bit speed and torque words, parameters held by the register bank.
// Notes: Register offsets are byte addresses on a 32-bit APB bus.
// Functional notes
// R1 - Clamp speed to zero when all conditions hold
// R2 - Any condition false: normal speed command
// R3 - Zero input zeroes, reverse input negates command
// R4 - Two inputs pick one of four preset speeds
// R5 - Two inputs pick one of four preset torques
// R6 - Mode three: position off, speed on
// R7 - Mode four: position off, torque on
// R8 - Mode five: speed off, torque on
// R9 - Gear setting zero: inputs pick numerator
// R10 - Position mode: clear input clears deviation
// R11 - Position mode: inhibit input blocks pulses
// R12 - Jog source: ccw input jogs ccw
// R13 - Jog source: cw input jogs cw
// R14 - Both jog inputs on: no jogging
// R15 - Pause input stops move when mode three
// R16 - Select position then trigger starts move
// R17 - Accept trigger only while zero-speed indicator set
// R18 - Synchronise inputs, trigger on rising edge
package sdi_pkg;
  localparam int unsigned CMD_W = 16;
  localparam logic [11:0] REG_MODE = 12'h000;
  localparam logic [11:0] REG_SRC = 12'h004;
  localparam logic [11:0] REG_THRESH = 12'h008;
  localparam logic [11:0] REG_JOG = 12'h00C;
  localparam logic [11:0] REG_EXT_CMD = 12'h010;
  localparam logic [11:0] REG_SPEED0 = 12'h020;
  localparam logic [11:0] REG_TORQUE0 = 12'h030;
  localparam logic [11:0] REG_GEAR0 = 12'h040;
  localparam logic [11:0] REG_STATUS = 12'h050;
  localparam logic [11:0] REG_OUT_CMD = 12'h054;
  localparam logic [11:0] REG_GEAR_OUT = 12'h058;
  localparam logic [3:0] MODE_SPEED = 4'h1;
  localparam logic [3:0] MODE_TORQUE = 4'h2;
  localparam logic [3:0] MODE_POS_SPEED = 4'h3;
  localparam logic [3:0] MODE_POS_TORQUE = 4'h4;
  localparam logic [3:0] MODE_SPEED_TORQUE = 4'h5;
  localparam logic [3:0] SSRC_EXTERNAL = 4'h0;
  localparam logic [3:0] SSRC_INTERNAL = 4'h1;
  localparam logic [3:0] SSRC_JOG = 4'h5;
  localparam logic [3:0] TSRC_INTERNAL = 4'h1;
  localparam logic [3:0] IPOS_MODE_PAUSE = 4'h3;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam int unsigned N_INPUTS = 20;
  localparam int unsigned SYNC_STAGES = 2;
  typedef enum logic [1:0] {SDI_POSITION, SDI_SPEED, SDI_TORQUE} sdi_ctrl_t;
  typedef enum {SDI_IDLE, SDI_MOVING} sdi_move_t;
endpackage

/* File: design/sdi_sync_if.sv */
`timescale 1ns/100ps
// Purpose: Carries raw and synchronised terminal levels between modules.
// Assumes: One clock domain after the synchroniser.
// Notes: Width follows the input count.
interface sdi_sync_if #(parameter int unsigned WIDTH = 19);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] sync;
  modport src (output raw, input sync);
  modport syn (input raw, output sync);
endinterface

/* File: tb/sdi_ctrl_model.sv */
`timescale 1ns/100ps
// Purpose: Motion controller model that picks a position register and pulses the move trigger.
// Assumes: The bench asks for a move with a one-cycle go pulse.
// Notes: The trigger is held for several cycles so that a long press can be seen to start only one move.
module sdi_ctrl_model (
  input wire logic pclk,
  input wire logic go,
  input wire logic [2:0] sel,
  output logic [2:0] position_select_inputs,
  output logic move_trigger_input
);
  logic [3:0] step_q;
  initial begin
    step_q = 4'h0;
    position_select_inputs = 3'h0;
    move_trigger_input = 1'b0;
  end
  // Select lines settle four cycles before the trigger rises, so the synchroniser never sees them skewed.
  always @(posedge pclk) begin
    if (go) begin
      position_select_inputs <= sel;
      step_q <= 4'h1;
    end else if (step_q != 4'h0) begin
      step_q <= step_q + 4'h1;
      move_trigger_input <= (step_q >= 4'h4) && (step_q < 4'hA);
    end
  end
endmodule

/* File: tb/sdi_func_logic_asserts.sv */
`timescale 1ns/100ps
// Purpose: Concurrent checks on the terminal decode outputs.
// Assumes: Outputs trail the pins by three edges.
// Notes: Checks wait five quiet cycles after reset or any write, as the mirror only tracks writes.
module sdi_func_logic_chk
  import sdi_pkg::*;
#(
  parameter int unsigned W = CMD_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic mode_switch_input,
  input wire logic deviation_clear_input,
  input wire logic pulse_inhibit_input,
  input wire logic ccw_jog_input,
  input wire logic cw_jog_input,
  input wire logic move_pause_input,
  input wire logic move_trigger_input,
  input wire logic zero_speed_indicator,
  input wire logic [1:0] active_ctrl_mode,
  input wire logic [W-1:0] speed_command,
  input wire logic deviation_clear,
  input wire logic pulse_accept,
  input wire logic move_hold,
  input wire logic move_start
);
  logic [11:0] mode_q;
  logic [3:0] src_q;
  logic [2:0] age_q;
  logic rdy;
  assign rdy = age_q >= 3'h5;
  // Mirror of mode and speed source; age counts quiet cycles since the last write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 12'h000;
      src_q <= 4'h0;
      age_q <= 3'h0;
    end else begin
      if (psel && penable && pwrite && paddr == REG_MODE) begin
        mode_q <= pwdata[11:0];
      end
      if (psel && penable && pwrite && paddr == REG_SRC) begin
        src_q <= pwdata[3:0];
      end
      age_q <= (psel && penable && pwrite) ? 3'h0 : ((age_q == 3'h7) ? age_q : age_q + 3'h1);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_mix_pos_speed: assert property (
    rdy && mode_q[3:0] == 4'h3 |-> active_ctrl_mode == ($past(mode_switch_input, 3) ? 2'h1 : 2'h0))
    else $error("mode three selection wrong");
  chk_mix_pos_torque: assert property (
    rdy && mode_q[3:0] == 4'h4 |-> active_ctrl_mode == ($past(mode_switch_input, 3) ? 2'h2 : 2'h0))
    else $error("mode four selection wrong");
  chk_mix_spd_torque: assert property (
    rdy && mode_q[3:0] == 4'h5 |-> active_ctrl_mode == ($past(mode_switch_input, 3) ? 2'h2 : 2'h1))
    else $error("mode five selection wrong");
  chk_dev_clear: assert property (
    rdy && mode_q[3:0] == 4'h0 |-> deviation_clear == $past(deviation_clear_input, 3))
    else $error("deviation clear wrong");
  chk_pulse_inhibit: assert property (
    rdy && mode_q[3:0] == 4'h0 |-> pulse_accept == !$past(pulse_inhibit_input, 3))
    else $error("pulse accept wrong");
  chk_move_pause: assert property (
    rdy && mode_q[7:0] == 8'h30 |-> move_hold == $past(move_pause_input, 3))
    else $error("move hold wrong");
  chk_jog_both: assert property (
    rdy && mode_q[3:0] == 4'h1 && src_q == 4'h5 && $past(ccw_jog_input, 3) && $past(cw_jog_input, 3)
    |-> speed_command == '0)
    else $error("jog with both inputs");
  chk_start_cause: assert property (
    rdy && move_start |-> $past(move_trigger_input, 3) && !$past(move_trigger_input, 4)
    && $past(zero_speed_indicator, 3))
    else $error("move start without cause");
  chk_start_once: assert property (
    rdy && $past(move_trigger_input, 3) && !$past(move_trigger_input, 4) && $past(zero_speed_indicator, 3)
    |-> move_start ##1 !move_start)
    else $error("move start missing");
endmodule

/* File: tb/tb_servo_digital_input_function_logic.sv */
`timescale 1ns/100ps
// Purpose: Self-checking bench for the terminal function decode.
// Assumes: Pins change right after a rising edge; results are read at the falling edge.
// Notes: Pin vector bits, high to low: clamp, zero, reverse, speed lo/hi, torque lo/hi, mode switch,
// gear lo/hi, clear, inhibit, ccw jog, cw jog, pause, zero-speed indicator.
module tb_servo_digital_input_function_logic;
  import sdi_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go, move_trigger_input;
  logic deviation_clear, pulse_accept, move_hold, move_start;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] active_ctrl_mode;
  logic [15:0] speed_command, torque_command, gear_numerator, pin_q;
  logic [2:0] sel, move_register, position_select_inputs;
  logic zero_speed_clamp_input, command_zero_input, command_reverse_input, speed_select_low;
  logic speed_select_high, torque_select_low, torque_select_high, mode_switch_input, gear_select_low;
  logic gear_select_high, deviation_clear_input, pulse_inhibit_input, ccw_jog_input, cw_jog_input;
  logic move_pause_input, zero_speed_indicator;
  logic [32:0] rq[$], rres;
  logic [18:0] pq[$];
  logic [2:0] mq[$];
  int error_cnt = 0, total_checks = 0;
  integer seed = 32'hAD62AC95;
  event rev, pev;
  assign {zero_speed_clamp_input, command_zero_input, command_reverse_input, speed_select_low, speed_select_high,
    torque_select_low, torque_select_high, mode_switch_input, gear_select_low, gear_select_high,
    deviation_clear_input, pulse_inhibit_input, ccw_jog_input, cw_jog_input, move_pause_input,
    zero_speed_indicator} = pin_q;
  sdi_func_logic i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .zero_speed_clamp_input, .command_zero_input, .command_reverse_input, .speed_select_low,
    .speed_select_high, .torque_select_low, .torque_select_high, .mode_switch_input, .gear_select_low,
    .gear_select_high, .deviation_clear_input, .pulse_inhibit_input, .ccw_jog_input, .cw_jog_input,
    .move_pause_input, .move_trigger_input, .position_select_inputs, .zero_speed_indicator,
    .active_ctrl_mode, .speed_command, .torque_command, .gear_numerator, .deviation_clear, .pulse_accept,
    .move_hold, .move_start, .move_register);
  sdi_ctrl_model i_ctrl (.pclk, .go, .sel, .position_select_inputs, .move_trigger_input);
  task automatic cmp(input string n, input logic [32:0] e, input logic [32:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // The request is held until pready is seen high; a dead slave is cut off after 50 edges.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [32:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    logic [32:0] r;
    rq.push_back(e);
    apb(1'b0, a, 32'h0, r);
    rres = r;
    -> rev;
  endtask
  // Sets the pins, lets the three-edge pipeline fill, then asks the observer to sample.
  task automatic chk(input logic [15:0] p, input logic [2:0] s, input logic [15:0] e);
    pin_q <= p;
    pq.push_back({s, e});
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    -> pev;
    @(posedge pclk);
  endtask
  function automatic logic [15:0] obs(input logic [2:0] s);
    case (s)
      3'h0: obs = {14'h0, active_ctrl_mode};
      3'h1: obs = speed_command;
      3'h2: obs = torque_command;
      3'h3: obs = gear_numerator;
      default: obs = {13'h0, move_hold, pulse_accept, deviation_clear};
    endcase
  endfunction
  function automatic logic [15:0] mode_exp(input logic [3:0] m, input logic sw);
    case (m)
      4'h1: mode_exp = 16'h1;
      4'h2: mode_exp = 16'h2;
      4'h3: mode_exp = sw ? 16'h1 : 16'h0;
      4'h4: mode_exp = sw ? 16'h2 : 16'h0;
      4'h5: mode_exp = sw ? 16'h2 : 16'h1;
      default: mode_exp = 16'h0;
    endcase
  endfunction
  // Observers take the oldest note when a result appears.
  always @(rev) cmp("register read", rq.pop_front(), rres);
  always @(pev) begin : pin_obs
    logic [18:0] pe;
    pe = pq.pop_front();
    cmp($sformatf("output %0d", pe[18:16]), {17'h0, pe[15:0]}, {17'h0, obs(pe[18:16])});
  end
  always @(negedge pclk) if (move_start === 1'b1) cmp("move register", {30'h0, mq.pop_front()}, {30'h0, move_register});
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Far beyond the roughly 700 cycles the sequence needs.
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    logic [31:0] v;
    {presetn, psel, penable, pwrite, paddr, pwdata, pin_q, go, sel} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(REG_MODE, 33'h0);
    rd(12'h0FC, {1'b1, 32'h0});
    for (int i = 0; i < 4; i++) begin
      wr(REG_SPEED0 + 12'(4 * i), 32'h1000 + i);
      wr(REG_TORQUE0 + 12'(4 * i), 32'h2000 + i);
      wr(REG_GEAR0 + 12'(4 * i), 32'h3000 + i);
    end
    rd(REG_SPEED0 + 12'h4, 33'h1001);
    wr(REG_THRESH, 32'hA);
    wr(REG_JOG, 32'h50);
    wr(REG_EXT_CMD, 32'h0030_FFFB);
    wr(REG_MODE, 32'h1);
    chk(16'h8000, 3'h1, 16'h0000);
    chk(16'h0000, 3'h1, 16'hFFFB);
    wr(REG_EXT_CMD, 32'h0030_0014);
    chk(16'h8000, 3'h1, 16'h0014);
    chk(16'h4000, 3'h1, 16'h0000);
    chk(16'h2000, 3'h1, 16'hFFEC);
    chk(16'h6000, 3'h1, 16'h0000);
    rd(REG_OUT_CMD, 33'h0);
    wr(REG_SRC, 32'h1);
    for (int i = 0; i < 4; i++) chk({3'h0, i[0], i[1], 11'h0}, 3'h1, 16'h1000 + 16'(i));
    wr(REG_SRC, 32'h5);
    chk(16'h0008, 3'h1, 16'h0050);
    chk(16'h0004, 3'h1, 16'hFFB0);
    chk(16'h000C, 3'h1, 16'h0000);
    wr(REG_MODE, 32'h2);
    wr(REG_SRC, 32'h0);
    chk(16'h2000, 3'h2, 16'hFFD0);
    wr(REG_SRC, 32'h10);
    for (int i = 0; i < 4; i++) chk({5'h0, i[0], i[1], 9'h0}, 3'h2, 16'h2000 + 16'(i));
    for (int i = 0; i < 30; i++) begin
      v = $random(seed);
      wr(REG_MODE, 32'(i % 6));
      chk(v[15:0], 3'h0, mode_exp(4'(i % 6), v[8]));
      chk(v[15:0], 3'h3, 16'h3000 + 16'({v[6], v[7]}));
    end
    wr(REG_MODE, 32'h130);
    chk(16'h0080, 3'h3, 16'h3000);
    wr(REG_MODE, 32'h30);
    chk(16'h0020, 3'h4, 16'h0003);
    chk(16'h0010, 3'h4, 16'h0000);
    chk(16'h0002, 3'h4, 16'h0006);
    pin_q <= 16'h0001;
    for (int i = 0; i < 4; i++) begin
      mq.push_back(3'(2 * i + 1));
      sel <= 3'(2 * i + 1);
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      repeat (20) @(posedge pclk);
    end
    pin_q <= 16'h0000;
    sel <= 3'h2;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    repeat (20) @(posedge pclk);
    cmp("moves left", 33'h0, 33'(mq.size()));
    tally_and_finish();
  end
endmodule
bind sdi_func_logic sdi_func_logic_chk #(.W(W)) i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .mode_switch_input, .deviation_clear_input, .pulse_inhibit_input, .ccw_jog_input, .cw_jog_input,
  .move_pause_input, .move_trigger_input, .zero_speed_indicator, .active_ctrl_mode, .speed_command,
  .deviation_clear, .pulse_accept, .move_hold, .move_start);
